// ---- design/lsd_line_engine.sv ----
`timescale 1ns/100ps
`include "lsd_defines.svh"

// ****************************************************************
// Line and stipple drawing engine.
// ****************************************************************

// How it works
// - Slope-draw write converts |dx|,|dy| into increments and error, then draws.
// - Slope inputs are 16-bit unsigned integers; error is relative to that endpoint.
// - Error arithmetic is 17 bits wide; accurate up to 32K major-axis pixels.
// - Setup-only write loads increments without drawing; fraction bits do not matter.
// - Writing initial error and length overrides what the next continue uses.
// - Each continue write draws up to 16 pixels from current address and error.
// - Four independent 16-bit channels each get their own pixel write strobe.
// - Active width field from bits 29:28 and 8:0 sets pixels per line.
// - Odd bit 31 hides the four extra skew pixels on refresh.
// - Block stipple writes up to 32 pixels coloured from the 8-entry pattern.
// - Every stipple mode writes at most 32 pixels per operation.
// - A slope write with no new address starts one pixel past the last.
// - Low 16 data bits mask pixels; all ones draws every pixel.
module lsd_line_engine #(
  parameter int PIX_W = 8,
  parameter int LINE_STRIDE = 1028
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic slopeDrawWr,
  input wire logic slopeSetupWr,
  input wire lsd_pkg::lsd_octant_t slopeOctant,
  input wire logic [15:0] slopeDx,
  input wire logic [15:0] slopeDy,
  input wire logic pixelAddrWr,
  input wire lsd_pkg::lsd_addr_t pixelAddrData,
  input wire logic initErrLenWr,
  input wire logic [15:0] initErrData,
  input wire logic [15:0] initLenData,
  input wire logic continueDrawWr,
  input wire logic [15:0] pixelMaskData,
  input wire logic [31:0] horizTimingCtrl,
  input wire logic spanWr,
  input wire logic blockMode,
  input wire logic [31:0] spanPattern,
  input wire logic [5:0] spanLen,
  input wire logic [PIX_W*8-1:0] blockColours,
  output logic [3:0] chanWrEn_r,
  output lsd_pkg::lsd_addr_t chanAddr_r [4],
  output logic drawBusy_r,
  output logic [10:0] activePixels_r,
  output logic [10:0] visiblePixels_r,
  output logic [15:0] remainLen_r,
  output logic spanValid_r,
  output logic [31:0] spanEnable_r,
  output logic [32*PIX_W-1:0] spanColour_r
);
  import lsd_pkg::*;

  lsd_state_e state_r;
  lsd_state_e state_nxt;
  lsd_octant_t octant_r;
  lsd_addr_t addr_r;
  logic signed [16:0] err_r;
  logic signed [16:0] errIncMinor_r;
  logic signed [16:0] errIncMajor_r;
  logic [15:0] major;
  logic [15:0] minor;
  logic [4:0] segCnt_r;
  logic [3:0] maskIdx_r;
  logic signed [24:0] stepMajor;
  logic signed [24:0] stepMinor;
  logic stepNow;
  logic segDone;
  logic [10:0] activeField;

  // Major axis is the larger delta; inputs taken as plain 16-bit counts.
  assign major = (slopeDy > slopeDx) ? slopeDy : slopeDx;
  assign minor = (slopeDy > slopeDx) ? slopeDx : slopeDy;

  // Address steps per octant: x is one pixel, y is one scan line.
  assign stepMajor = octant_r[2] ? (octant_r[1] ? -25'(LINE_STRIDE) : 25'(LINE_STRIDE))
                                 : (octant_r[0] ? -25'sd1 : 25'sd1);
  assign stepMinor = octant_r[2] ? (octant_r[0] ? -25'sd1 : 25'sd1)
                                 : (octant_r[1] ? -25'(LINE_STRIDE) : 25'(LINE_STRIDE));

  // A pixel is stepped while drawing, up to 16 per segment and the line length.
  assign stepNow = (state_r == LSD_DRAW) && (remainLen_r != 16'h0000);
  assign segDone = (state_r == LSD_DRAW) &&
                   ((remainLen_r == 16'h0000) || (segCnt_r == `LSD_SEG_PIXELS - 5'd1 && stepNow));

  // Next-state choice for the engine.
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      LSD_IDLE: if (slopeDrawWr || continueDrawWr) state_nxt = LSD_DRAW;
      LSD_SETUP: state_nxt = LSD_IDLE;
      LSD_DRAW: if (segDone) state_nxt = LSD_IDLE;
    endcase
    if (slopeSetupWr && state_r == LSD_IDLE) state_nxt = LSD_SETUP;
  end

  // State register.
  always_ff @(posedge clk)
  begin
    if (srst) state_r <= LSD_IDLE;
    else state_r <= state_nxt;
  end

  // Setup: 2*minor and 2*minor-2*major increments, error 2*minor-major.
  // The ratio is scale free, so 12.4 inputs give increments 16 times larger but the same steps.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      octant_r <= '0;
      errIncMinor_r <= '0;
      errIncMajor_r <= '0;
      err_r <= '0;
      remainLen_r <= '0;
    end
    else if ((slopeDrawWr || slopeSetupWr) && state_r == LSD_IDLE)
    begin
      octant_r <= slopeOctant;
      errIncMinor_r <= 17'({minor, 1'b0});
      errIncMajor_r <= 17'({minor, 1'b0}) - 17'({major, 1'b0});
      err_r <= 17'({minor, 1'b0}) - 17'(major);
      remainLen_r <= major;
    end
    else if (initErrLenWr && state_r == LSD_IDLE)
    begin
      err_r <= 17'(signed'(initErrData));
      remainLen_r <= initLenData;
    end
    else if (stepNow)
    begin
      err_r <= err_r[16] ? err_r + errIncMinor_r : err_r + errIncMajor_r;
      remainLen_r <= remainLen_r - 16'h0001;
    end
  end

  // Address keeps running past the last pixel, so a connected line needs no new address.
  always_ff @(posedge clk)
  begin
    if (srst) addr_r <= `LSD_RST_ADDR;
    else if (pixelAddrWr && state_r == LSD_IDLE) addr_r <= pixelAddrData;
    else if (stepNow)
      addr_r <= 24'(25'(addr_r) + stepMajor + (err_r[16] ? 25'sd0 : stepMinor));
  end

  // Segment pixel counter and mask bit index.
  always_ff @(posedge clk)
  begin
    if (srst || state_r != LSD_DRAW)
    begin
      segCnt_r <= '0;
      maskIdx_r <= '0;
    end
    else if (stepNow)
    begin
      segCnt_r <= segCnt_r + 5'd1;
      maskIdx_r <= maskIdx_r + 4'd1;
    end
  end

  // Each pixel goes to the channel its address falls in; channels run independently.
  genvar ch;
  generate
    for (ch = 0; ch < `LSD_CHANNELS; ch++)
    begin : g_chan
      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          chanWrEn_r[ch] <= 1'b0;
          chanAddr_r[ch] <= '0;
        end
        else
        begin
          chanWrEn_r[ch] <= stepNow && pixelMaskData[maskIdx_r] && (addr_r[1:0] == 2'(ch));
          chanAddr_r[ch] <= addr_r;
        end
      end
    end
  endgenerate

  // Active width field is split over two places; odd bit trims the skew pixels.
  assign activeField = {horizTimingCtrl[`LSD_HC_ACT_HI_MSB:`LSD_HC_ACT_HI_LSB],
                        horizTimingCtrl[`LSD_HC_ACT_LO_MSB:`LSD_HC_ACT_LO_LSB]};

  // Refresh timing outputs and the draw busy flag.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      activePixels_r <= '0;
      visiblePixels_r <= '0;
      drawBusy_r <= 1'b0;
    end
    else
    begin
      activePixels_r <= activeField;
      visiblePixels_r <= horizTimingCtrl[`LSD_HC_ODD_BIT] ? activeField - `LSD_SKEW_PIXELS : activeField;
      drawBusy_r <= (state_nxt != LSD_IDLE);
    end
  end

  // Stipple span path.
  lsd_stipple_span #(.PIX_W(PIX_W)) u_span (
    .clk(clk),
    .srst(srst),
    .spanWr(spanWr),
    .blockMode(blockMode),
    .spanPattern(spanPattern),
    .spanLen(spanLen),
    .blockColours(blockColours),
    .spanValid_r(spanValid_r),
    .spanEnable_r(spanEnable_r),
    .spanColour_r(spanColour_r)
  );

  sequence s_cont_start;
    state_r == LSD_IDLE && continueDrawWr && remainLen_r >= 16'(`LSD_SEG_PIXELS);
  endsequence

  // The segment counter proves the sixteen drawing cycles, so no long repetition is unrolled.
  sequence s_full_seg;
    (state_r == LSD_DRAW) ##15 (state_r == LSD_DRAW && segCnt_r == `LSD_SEG_PIXELS - 5'd1);
  endsequence

  chk_seg_length: assert property (@(posedge clk) disable iff (srst)
    s_cont_start |=> s_full_seg ##1 state_r == LSD_IDLE) else $error("segment not 16 pixels");
  chk_len_decrement: assert property (@(posedge clk) disable iff (srst)
    stepNow |=> remainLen_r == $past(remainLen_r) - 16'd1) else $error("length not decremented");
  chk_setup_nodraw: assert property (@(posedge clk) disable iff (srst)
    (slopeSetupWr && !slopeDrawWr && !continueDrawWr && state_r == LSD_IDLE) |=> ##1 state_r == LSD_IDLE)
    else $error("setup started a draw");
  chk_slope_start: assert property (@(posedge clk) disable iff (srst)
    (slopeDrawWr && !slopeSetupWr && state_r == LSD_IDLE) |=> state_r == LSD_DRAW && remainLen_r == $past(major))
    else $error("slope write did not start");
  chk_init_override: assert property (@(posedge clk) disable iff (srst)
    (initErrLenWr && !slopeDrawWr && !slopeSetupWr && state_r == LSD_IDLE) |=> remainLen_r == $past(initLenData))
    else $error("length override lost");
  chk_octant_load: assert property (@(posedge clk) disable iff (srst)
    (slopeSetupWr && state_r == LSD_IDLE) |=> octant_r == $past(slopeOctant)) else $error("octant not taken");
  chk_odd_trim: assert property (@(posedge clk) disable iff (srst)
    horizTimingCtrl[`LSD_HC_ODD_BIT] |=> visiblePixels_r == $past(activeField) - `LSD_SKEW_PIXELS)
    else $error("odd trim wrong");
  chk_mask_gate: assert property (@(posedge clk) disable iff (srst)
    (stepNow && !pixelMaskData[maskIdx_r]) |=> chanWrEn_r == 4'h0) else $error("masked pixel written");
  chk_addr_hold: assert property (@(posedge clk) disable iff (srst)
    (state_r == LSD_IDLE && !pixelAddrWr) |=> addr_r == $past(addr_r)) else $error("address moved idle");
endmodule : lsd_line_engine

// ---- design/lsd_stipple_span.sv ----
`timescale 1ns/100ps
`include "lsd_defines.svh"

// Turns one stipple span write into per-pixel enables and block colours.
module lsd_stipple_span #(
  parameter int PIX_W = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic spanWr,
  input wire logic blockMode,
  input wire logic [31:0] spanPattern,
  input wire logic [5:0] spanLen,
  input wire logic [PIX_W*`LSD_BLK_COLOURS-1:0] blockColours,
  output logic spanValid_r,
  output logic [31:0] spanEnable_r,
  output logic [32*PIX_W-1:0] spanColour_r
);
  import lsd_pkg::*;

  logic [31:0] lenMask;
  logic [5:0] clampLen;
  logic [32*PIX_W-1:0] colourNxt;

  // Never more than 32 pixels per write, however long the request.
  assign clampLen = (spanLen > `LSD_STIP_PIXELS) ? `LSD_STIP_PIXELS : spanLen;

  // Each pixel takes its colour from the repeating 8-entry pattern.
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++)
    begin : g_pix
      assign lenMask[gi] = (6'(gi) < clampLen);
      assign colourNxt[gi*PIX_W +: PIX_W] = blockColours[(gi % `LSD_BLK_COLOURS)*PIX_W +: PIX_W];
    end
  endgenerate

  // Register the span; non-block modes pass colour zero for the pixel datapath.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      spanValid_r <= 1'b0;
      spanEnable_r <= '0;
      spanColour_r <= '0;
    end
    else
    begin
      spanValid_r <= spanWr;
      if (spanWr)
      begin
        spanEnable_r <= spanPattern & lenMask;
        spanColour_r <= blockMode ? colourNxt : '0;
      end
    end
  end

  chk_span_cap: assert property (@(posedge clk) disable iff (srst)
    spanWr |=> spanValid_r && ($countones(spanEnable_r) <= 32'($past(clampLen)))) else $error("span too wide");
endmodule : lsd_stipple_span

// ---- include/lsd_defines.svh ----
`ifndef LSD_DEFINES_SVH
`define LSD_DEFINES_SVH

// ****************************************************************
// Field positions and sizes.
// ****************************************************************
`define LSD_SEG_PIXELS 5'd16
`define LSD_STIP_PIXELS 6'd32
`define LSD_BLK_COLOURS 8
`define LSD_CHANNELS 4
`define LSD_HC_ODD_BIT 31
`define LSD_HC_ACT_HI_MSB 29
`define LSD_HC_ACT_HI_LSB 28
`define LSD_HC_ACT_LO_MSB 8
`define LSD_HC_ACT_LO_LSB 0
`define LSD_SKEW_PIXELS 11'd4
`define LSD_MASK_ALL 16'hffff

// ****************************************************************
// Reset values.
// ****************************************************************
`define LSD_RST_ADDR 24'h000000
`define LSD_RST_HCTRL 32'h00000000
`define LSD_RST_MASK 16'hffff

`endif

// ---- include/lsd_pkg.sv ----
package lsd_pkg;
  // Drawing state of the line engine.
  typedef enum logic [1:0] {LSD_IDLE, LSD_SETUP, LSD_DRAW} lsd_state_e;
  // Three-bit octant code: bit2 y-major, bit1 dy negative, bit0 dx negative.
  typedef logic [2:0] lsd_octant_t;
  // Frame-buffer pixel address.
  typedef logic [23:0] lsd_addr_t;
endpackage : lsd_pkg

// ---- verification/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  import lsd_pkg::*;
  localparam int PIX_W = 8;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic slopeDrawWr = 1'b0;
  logic slopeSetupWr = 1'b0;
  logic pixelAddrWr = 1'b0;
  logic initErrLenWr = 1'b0;
  logic continueDrawWr = 1'b0;
  logic spanWr = 1'b0;
  logic blockMode = 1'b0;
  lsd_octant_t slopeOctant = 3'h0;
  logic [15:0] slopeDx = 16'h0000;
  logic [15:0] slopeDy = 16'h0000;
  logic [15:0] initErrData = 16'h0000;
  logic [15:0] initLenData = 16'h0000;
  logic [15:0] pixelMaskData = 16'hffff;
  lsd_addr_t pixelAddrData = 24'h000000;
  logic [31:0] horizTimingCtrl = 32'h00000000;
  logic [31:0] spanPattern = 32'hdeadbeef;
  logic [5:0] spanLen = 6'h00;
  logic [PIX_W*8-1:0] blockColours = 64'h8877665544332211;
  logic [3:0] chanWrEn_r;
  lsd_addr_t chanAddr_r [4];
  logic drawBusy_r;
  logic [10:0] activePixels_r;
  logic [10:0] visiblePixels_r;
  logic [15:0] remainLen_r;
  logic spanValid_r;
  logic [31:0] spanEnable_r;
  logic [32*PIX_W-1:0] spanColour_r;
  int num_errors = 0;
  int num_checks = 0;
  lsd_addr_t pix [$];

  // Half period of 2.5 ns gives the 200 MHz drawing clock.
  always #2.5 clk = ~clk;

  lsd_line_engine #(.PIX_W(PIX_W), .LINE_STRIDE(1028)) lsd_line_engine_i (
    .clk(clk), .srst(srst), .slopeDrawWr(slopeDrawWr), .slopeSetupWr(slopeSetupWr),
    .slopeOctant(slopeOctant), .slopeDx(slopeDx), .slopeDy(slopeDy), .pixelAddrWr(pixelAddrWr),
    .pixelAddrData(pixelAddrData), .initErrLenWr(initErrLenWr), .initErrData(initErrData),
    .initLenData(initLenData), .continueDrawWr(continueDrawWr), .pixelMaskData(pixelMaskData),
    .horizTimingCtrl(horizTimingCtrl), .spanWr(spanWr), .blockMode(blockMode),
    .spanPattern(spanPattern), .spanLen(spanLen), .blockColours(blockColours),
    .chanWrEn_r(chanWrEn_r), .chanAddr_r(chanAddr_r), .drawBusy_r(drawBusy_r),
    .activePixels_r(activePixels_r), .visiblePixels_r(visiblePixels_r), .remainLen_r(remainLen_r),
    .spanValid_r(spanValid_r), .spanEnable_r(spanEnable_r), .spanColour_r(spanColour_r));

  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  task automatic check(input logic [63:0] seen, input logic [63:0] expd);
    num_checks++;
    if (seen !== expd)
    begin
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, expd);
      num_errors++;
    end
  endtask : check

  task automatic report_and_stop();
    if (num_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  // Strobes are raised at a falling edge and dropped one cycle later.
  task automatic drop_all();
    @(negedge clk);
    {slopeDrawWr, slopeSetupWr, pixelAddrWr, initErrLenWr, continueDrawWr, spanWr} = 6'h00;
  endtask : drop_all

  // Records every pixel strobe; the strobe only lasts one cycle.
  task automatic collect(input int cycles);
    pix.delete();
    repeat (cycles)
    begin
      @(negedge clk);
      for (int c = 0; c < 4; c++)
        if (chanWrEn_r[c] === 1'b1)
        begin
          pix.push_back(chanAddr_r[c]);
          check(c, chanAddr_r[c][1:0]);
        end
    end
  endtask : collect

  // Loads octant and slope, then address, error and length, then continues.
  task automatic line(input lsd_octant_t o, input logic [15:0] dx, input logic [15:0] dy,
    input lsd_addr_t a, input logic [15:0] e, input logic [15:0] len);
    slopeSetupWr = 1'b1;
    slopeOctant = o;
    slopeDx = dx;
    slopeDy = dy;
    drop_all();
    collect(6);
    check(pix.size(), 0);
    pixelAddrWr = 1'b1;
    pixelAddrData = a;
    drop_all();
    initErrLenWr = 1'b1;
    initErrData = e;
    initLenData = len;
    drop_all();
    continueDrawWr = 1'b1;
    drop_all();
    collect(24);
  endtask : line

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic test_hctrl();
    horizTimingCtrl = 32'ha0000104;
    repeat (3) @(negedge clk);
    check(activePixels_r, 11'h504);
    check(visiblePixels_r, 11'h500);
    horizTimingCtrl = 32'h20000104;
    repeat (3) @(negedge clk);
    check(visiblePixels_r, 11'h504);
  endtask : test_hctrl

  // A span length above 32 must still enable only 32 pixels.
  task automatic test_span(input logic blk, input logic [5:0] len, input logic [31:0] expEn);
    int hits;
    hits = 0;
    spanWr = 1'b1;
    blockMode = blk;
    spanLen = len;
    drop_all();
    repeat (3)
    begin
      if (spanValid_r === 1'b1)
      begin
        hits++;
        check(spanEnable_r, expEn);
        for (int i = 0; i < 32; i++)
          check(spanColour_r[i*PIX_W+:PIX_W], blk ? blockColours[(i%8)*PIX_W+:PIX_W] : 8'h00);
      end
      @(negedge clk);
    end
    check(hits, 1);
  endtask : test_span

  // Twenty pixels: one full segment, then a short one, then a joined line.
  task automatic test_segments();
    line(3'h0, 16'h0010, 16'h0000, 24'h000100, 16'hfff0, 16'h0014);
    check(pix.size(), 16);
    foreach (pix[k]) check(pix[k], 24'h000100 + k);
    check(remainLen_r, 16'h0004);
    check(drawBusy_r, 1'b0);
    continueDrawWr = 1'b1;
    drop_all();
    collect(24);
    check(pix.size(), 4);
    foreach (pix[k]) check(pix[k], 24'h000110 + k);
    check(remainLen_r, 16'h0000);
    slopeDrawWr = 1'b1;
    slopeDx = 16'h0003;
    drop_all();
    collect(24);
    check(pix.size(), 3);
    if (pix.size() > 0) check(pix[0], 24'h000114);
  endtask : test_segments

  // Octant 7 steps up one scan line per pixel.
  task automatic test_octant7();
    line(3'h7, 16'h0000, 16'h0004, 24'h010000, 16'hfffc, 16'h0004);
    check(pix.size(), 4);
    foreach (pix[k]) check(pix[k], 24'h010000 - k * 1028);
  endtask : test_octant7

  // Cleared mask bits suppress pixels while the address keeps stepping.
  task automatic test_mask();
    pixelMaskData = 16'h00a5;
    line(3'h0, 16'h0010, 16'h0000, 24'h000200, 16'hfff0, 16'h0008);
    check(pix.size(), 4);
    if (pix.size() == 4) check({pix[0][7:0], pix[1][7:0], pix[2][7:0], pix[3][7:0]}, 32'h00020507);
    pixelMaskData = 16'hffff;
  endtask : test_mask

  // A sloped line in octant 3 takes a minor step whenever the error is not negative.
  // Error starts at 2*2-4 = 0, so steps go both, major, both from the start address.
  task automatic test_diag();
    pixelAddrWr = 1'b1;
    pixelAddrData = 24'h020000;
    drop_all();
    slopeDrawWr = 1'b1;
    slopeOctant = 3'h3;
    slopeDx = 16'h0004;
    slopeDy = 16'h0002;
    drop_all();
    check(drawBusy_r, 1'b1);
    collect(24);
    check(pix.size(), 4);
    if (pix.size() == 4)
    begin
      check(pix[0], 24'h020000);
      check(pix[1], 24'h01fbfb);
      check(pix[2], 24'h01fbfa);
      check(pix[3], 24'h01f7f5);
    end
    check(remainLen_r, 16'h0000);
    check(drawBusy_r, 1'b0);
  endtask : test_diag

  // ****************************************************************
  // Main sequence and watchdog.
  // ****************************************************************
  initial
  begin
    repeat (2) @(negedge clk);
    srst = 1'b0;
    check({chanWrEn_r, drawBusy_r, spanValid_r, remainLen_r}, 22'h000000);
    test_hctrl();
    test_span(1'b1, 6'd40, 32'hdeadbeef);
    test_span(1'b0, 6'd5, 32'h0000000f);
    test_segments();
    test_octant7();
    test_mask();
    test_diag();
    report_and_stop();
  end

  // The tests take some 200 cycles; this span leaves a wide margin.
  initial
  begin
    #20000;
    num_errors++;
    report_and_stop();
  end
endmodule : tb_top
